// File: src/ptp_time_counter_waveform.sv
// time keeping block: free counter, syntonized counter, frame stamps,
// waveform output, all behind an APB slave
// assumes every input is synchronous to clk; frame strobes are 1-cycle
`timescale 1ns/100ps
`default_nettype none
// How it works
// R1: free counter counts at 120 MHz rate
// R2: 32-bit free count wraps about every 35 s
// R3: free counter runs only when enabled
// R4: every received frame gets a stamp; code stamps one only while counter and frame stamp enables are both set
// R5: transmit stamp only when capture requested
// R6: capture input copies free count to register
// R7: syntonized counter: 32-bit seconds, 32-bit nanoseconds
// R8: nanoseconds reaching compare clear, seconds increment
// R9: syntonized counter advances only when enabled
// R10: three stamp formats selectable
// R11: frame stamping needs frame stamp enable
// R12: software programs periods in multiples of 16
// R13: correction 0..15 compensates period quantization
// R14: start time match starts waveform once
// R15: waveform idles at programmable level, default 0
// R16: software writes start time last
// R17: writing stop halts toggling
// R18: stopped waveform returns to idle level
// R19: high then low periods repeat until stopped
module ptp_time_counter_waveform (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        freeCountCaptureInput,
   input  wire logic        rxFrameStart,
   input  wire logic        txFrameStart,
   input  wire logic        txCaptureRequest,
   output logic      [63:0] rxStamp,
   output logic             rxStampValid,
   output logic             rxStampWide,
   output logic             waveOutput
);
   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic                     timestampCounterEnable;
   logic                     frameStampEnable;
   ptp_time_pkg::stamp_fmt_t stampFormat;
   logic [31:0]              oneSecondCompare;
   logic [31:0]              synSec;
   logic [31:0]              synNs;
   logic [31:0]              freeCount;
   logic [31:0]              freeCountCaptureValue;
   logic [31:0]              waveHighPeriod;
   logic [31:0]              waveLowPeriod;
   logic [3:0]               waveQuantCorrection;
   logic [31:0]              waveStartTime;
   logic                     waveIdleLevel;
   logic                     waveArm;
   logic                     waveStop;
   logic                     waveRunning;
   logic [63:0]              txStamp;
   logic                     txStampReady;
   logic                     captPrev;
   logic [31:0]              readMux;
   logic                     addrHit;
   logic                     wrEn;
   logic                     stampOn;
   logic                     captRise;
   logic                     txTake;

   assign wrEn     = psel & penable & pready & pwrite;
   assign stampOn  = timestampCounterEnable & frameStampEnable;
   assign captRise = freeCountCaptureInput & ~captPrev;
   assign txTake   = stampOn & txFrameStart & txCaptureRequest;

   function automatic logic [63:0] fmtStamp(
      input ptp_time_pkg::stamp_fmt_t fmt,
      input logic [31:0]              sec,
      input logic [31:0]              ns,
      input logic [31:0]              free
   );
      logic [63:0] value;
      value = 64'h0;
      unique case (fmt)
         ptp_time_pkg::FMT_SHORT: value = {32'h0, sec[1:0], ns[29:0]};
         ptp_time_pkg::FMT_LONG:  value = {sec, 2'h0, ns[29:0]};
         ptp_time_pkg::FMT_FREE:  value = {32'h0, free};
         default:                 value = {32'h0, sec[1:0], ns[29:0]};
      endcase
      return value;
   endfunction

   // ----------------------------------------------------------------
   // apb slave: data and ready prepared in setup, one access cycle
   // ----------------------------------------------------------------
   always_comb begin
      readMux = 32'h0;
      addrHit = 1'b1;
      unique case (paddr)
         ptp_time_pkg::ADDR_CTRL: begin
            readMux[ptp_time_pkg::CTRL_TIMESTAMP_COUNTER_ENABLE] = timestampCounterEnable;
            readMux[ptp_time_pkg::CTRL_FRAME_STAMP_ENABLE]  = frameStampEnable;
            readMux[ptp_time_pkg::CTRL_FMT_LO +: 2] = stampFormat;
         end
         ptp_time_pkg::ADDR_ONE_SEC:   readMux = oneSecondCompare;
         ptp_time_pkg::ADDR_SEC:       readMux = synSec;
         ptp_time_pkg::ADDR_NS:        readMux = synNs;
         ptp_time_pkg::ADDR_FREE:      readMux = freeCount;
         ptp_time_pkg::ADDR_FREE_CAPT: readMux = freeCountCaptureValue;
         ptp_time_pkg::ADDR_WAVE_HI:   readMux = waveHighPeriod;
         ptp_time_pkg::ADDR_WAVE_LO:   readMux = waveLowPeriod;
         ptp_time_pkg::ADDR_WAVE_QE:   readMux = 32'(waveQuantCorrection);
         ptp_time_pkg::ADDR_WAVE_GO:   readMux = waveStartTime;
         ptp_time_pkg::ADDR_WAVE_CTRL: begin
            readMux[ptp_time_pkg::WCTL_IDLE] = waveIdleLevel;
            readMux[ptp_time_pkg::WCTL_RUN]  = waveRunning;
         end
         ptp_time_pkg::ADDR_TX_HI:     readMux = txStamp[63:32];
         ptp_time_pkg::ADDR_TX_LO:     readMux = txStamp[31:0];
         ptp_time_pkg::ADDR_STATUS:    readMux[ptp_time_pkg::STAT_TX] = txStampReady;
         default:                      addrHit = 1'b0;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0;
      end else if (psel && !penable) begin
         pready  <= 1'b1;
         pslverr <= ~addrHit;
         prdata  <= (pwrite || !addrHit) ? 32'h0 : readMux;
      end else begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0;
      end
   end

   // ----------------------------------------------------------------
   // control registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         timestampCounterEnable <= 1'b0;
         frameStampEnable       <= 1'b0;
         stampFormat            <= ptp_time_pkg::FMT_SHORT;
         oneSecondCompare       <= ptp_time_pkg::ONE_SEC_RESET;
      end else if (wrEn && paddr == ptp_time_pkg::ADDR_CTRL) begin
         timestampCounterEnable <= pwdata[ptp_time_pkg::CTRL_TIMESTAMP_COUNTER_ENABLE];
         frameStampEnable       <= pwdata[ptp_time_pkg::CTRL_FRAME_STAMP_ENABLE];
         stampFormat <= ptp_time_pkg::stamp_fmt_t'(pwdata[ptp_time_pkg::CTRL_FMT_LO +: 2]);
      end else if (wrEn && paddr == ptp_time_pkg::ADDR_ONE_SEC) begin
         oneSecondCompare <= pwdata;
      end
   end

   // periods are taken as written; multiples of 16 are software's duty
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         waveHighPeriod      <= 32'h0;
         waveLowPeriod       <= 32'h0;
         waveQuantCorrection <= 4'h0;
         waveStartTime       <= 32'h0;
         waveIdleLevel       <= 1'b0; // R15
         waveArm             <= 1'b0;
         waveStop            <= 1'b0;
      end else begin
         waveArm  <= 1'b0;
         waveStop <= 1'b0;
         if (wrEn) begin
            unique case (paddr)
               ptp_time_pkg::ADDR_WAVE_HI: waveHighPeriod <= pwdata; // R12
               ptp_time_pkg::ADDR_WAVE_LO: waveLowPeriod <= pwdata; // R12
               ptp_time_pkg::ADDR_WAVE_QE: waveQuantCorrection <= pwdata[3:0]; // R13
               ptp_time_pkg::ADDR_WAVE_GO: begin
                  waveStartTime <= pwdata;
                  waveArm       <= 1'b1; // R16
               end
               ptp_time_pkg::ADDR_WAVE_CTRL: begin
                  waveIdleLevel <= pwdata[ptp_time_pkg::WCTL_IDLE]; // R15
                  waveStop      <= pwdata[ptp_time_pkg::WCTL_STOP]; // R17
               end
               default: ;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // counters
   // ----------------------------------------------------------------
   free_run_counter freeCounter (
      .clk    (clk),
      .rst_n  (rst_n),
      .enable (timestampCounterEnable),
      .count  (freeCount)
   );

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         captPrev              <= 1'b0;
         freeCountCaptureValue <= 32'h0;
      end else begin
         captPrev <= freeCountCaptureInput;
         if (captRise) begin
            freeCountCaptureValue <= freeCount; // R6
         end
      end
   end

   // ns steps by one clock period, so it may overshoot the compare
   // value by less than a step before clearing
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         synSec <= 32'h0;
         synNs  <= 32'h0;
      end else if (timestampCounterEnable) begin // R9
         if (synNs >= oneSecondCompare) begin
            synNs  <= 32'h0; // R8
            synSec <= synSec + 32'h1; // R7 R8
         end else begin
            synNs <= synNs + ptp_time_pkg::NS_STEP; // R7
         end
      end
   end

   // ----------------------------------------------------------------
   // frame stamps
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rxStamp      <= 64'h0;
         rxStampValid <= 1'b0;
         rxStampWide  <= 1'b0;
      end else begin
         rxStampValid <= stampOn & rxFrameStart; // R4 R11
         if (stampOn && rxFrameStart) begin
            rxStamp     <= fmtStamp(stampFormat, synSec, synNs, freeCount); // R10
            rxStampWide <= (stampFormat == ptp_time_pkg::FMT_LONG);
         end
      end
   end

   // a new capture wins over a clear in the same cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         txStamp      <= 64'h0;
         txStampReady <= 1'b0;
      end else begin
         if (txTake) begin
            txStamp      <= fmtStamp(stampFormat, synSec, synNs, freeCount); // R5 R10
            txStampReady <= 1'b1; // R5
         end else if (wrEn && paddr == ptp_time_pkg::ADDR_STATUS
                      && pwdata[ptp_time_pkg::STAT_TX]) begin
            txStampReady <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // waveform
   // ----------------------------------------------------------------
   wave_gen waveGen (
      .clk        (clk),
      .rst_n      (rst_n),
      .tick       (timestampCounterEnable),
      .timeNs     (synNs),
      .highPeriod (waveHighPeriod),
      .lowPeriod  (waveLowPeriod),
      .quantCorr  (waveQuantCorrection),
      .startTime  (waveStartTime),
      .armPulse   (waveArm),
      .stopPulse  (waveStop),
      .idleLevel  (waveIdleLevel),
      .waveOut    (waveOutput),
      .running    (waveRunning)
   );

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   property p_freeStep;
      timestampCounterEnable |=>
         (32'(freeCount - $past(freeCount)) == ptp_time_pkg::FREE_WHOLE) ||
         (32'(freeCount - $past(freeCount)) == ptp_time_pkg::FREE_WHOLE + 32'h1);
   endproperty
   a_freeStep: assert property (p_freeStep) else $error("free count step wrong"); // R1

   property p_freeHold;
      !timestampCounterEnable |=> $stable(freeCount);
   endproperty
   a_freeHold: assert property (p_freeHold) else $error("free count moved"); // R3

   property p_capture;
      captRise |=> freeCountCaptureValue == $past(freeCount);
   endproperty
   a_capture: assert property (p_capture) else $error("capture value wrong"); // R6

   property p_nsWrap;
      timestampCounterEnable && synNs >= oneSecondCompare |=>
         synNs == 32'h0 && synSec == $past(synSec) + 32'h1;
   endproperty
   a_nsWrap: assert property (p_nsWrap) else $error("second rollover wrong"); // R8

   property p_synHold;
      !timestampCounterEnable |=> $stable(synNs) && $stable(synSec);
   endproperty
   a_synHold: assert property (p_synHold) else $error("syntonized moved"); // R9

   property p_rxStamp;
      stampOn && rxFrameStart |=> rxStampValid &&
         rxStamp == fmtStamp($past(stampFormat), $past(synSec),
                             $past(synNs), $past(freeCount));
   endproperty
   a_rxStamp: assert property (p_rxStamp) else $error("rx stamp missing"); // R4

   property p_noStamp;
      !frameStampEnable |=> !rxStampValid;
   endproperty
   a_noStamp: assert property (p_noStamp) else $error("stamp while disabled"); // R11

   property p_txOnlyReq;
      $rose(txStampReady) |-> $past(txCaptureRequest) && $past(txFrameStart);
   endproperty
   a_txOnlyReq: assert property (p_txOnlyReq) else $error("tx stamp unrequested"); // R5

   property p_shortFmt;
      rxStampValid && !rxStampWide |-> rxStamp[63:32] == 32'h0;
   endproperty
   a_shortFmt: assert property (p_shortFmt) else $error("short stamp too wide"); // R10

   property p_stop;
      waveStop |=> waveOutput == $past(waveIdleLevel) && !waveRunning;
   endproperty
   a_stop: assert property (p_stop) else $error("stop did not idle"); // R18

   property p_idle;
      !waveRunning && !waveStop ##1 !waveRunning |-> waveOutput == $past(waveIdleLevel);
   endproperty
   a_idle: assert property (p_idle) else $error("idle level wrong"); // R15

   property p_startLevel;
      $rose(waveRunning) |-> waveOutput != waveIdleLevel;
   endproperty
   a_startLevel: assert property (p_startLevel) else $error("start level wrong"); // R14

   c_rxStamp:  cover property (stampOn && rxFrameStart ##1 rxStampValid);
   c_waveRun:  cover property ($rose(waveRunning) ##[1:200] $changed(waveOutput));
   c_secRoll:  cover property (timestampCounterEnable && synNs >= oneSecondCompare);
   c_waveStop: cover property (waveRunning ##1 waveStop);
endmodule
`default_nettype wire

// File: src/ptp_time_pkg.sv
// constants shared by the time keeping block and its helpers
// assumes a single 25 MHz clock and a 32-bit APB register bus
package ptp_time_pkg;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int          CLK_MHZ       = 25;
   localparam int          FREE_MHZ      = 120;
   localparam int          CLK_PERIOD_NS = 1000 / CLK_MHZ;
   localparam logic [31:0] NS_STEP       = 32'(CLK_PERIOD_NS);
   // free counter advances FREE_MHZ/CLK_MHZ counts per clock, kept exact
   // by a remainder in units of 1/CLK_MHZ
   localparam logic [31:0] FREE_WHOLE    = 32'(FREE_MHZ / CLK_MHZ);
   localparam logic [4:0]  FREE_FRAC     = 5'(FREE_MHZ % CLK_MHZ);
   localparam logic [4:0]  FREE_DEN      = 5'(CLK_MHZ);
   localparam logic [31:0] ONE_SEC_RESET = 32'h3B9ACA00;

   // ----------------------------------------------------------------
   // register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL      = 8'h00;
   localparam logic [7:0] ADDR_ONE_SEC   = 8'h04;
   localparam logic [7:0] ADDR_SEC       = 8'h08;
   localparam logic [7:0] ADDR_NS        = 8'h0C;
   localparam logic [7:0] ADDR_FREE      = 8'h10;
   localparam logic [7:0] ADDR_FREE_CAPT = 8'h14;
   localparam logic [7:0] ADDR_WAVE_HI   = 8'h18;
   localparam logic [7:0] ADDR_WAVE_LO   = 8'h1C;
   localparam logic [7:0] ADDR_WAVE_QE   = 8'h20;
   localparam logic [7:0] ADDR_WAVE_GO   = 8'h24;
   localparam logic [7:0] ADDR_WAVE_CTRL = 8'h28;
   localparam logic [7:0] ADDR_TX_HI     = 8'h2C;
   localparam logic [7:0] ADDR_TX_LO     = 8'h30;
   localparam logic [7:0] ADDR_STATUS    = 8'h34;

   // field positions
   localparam int CTRL_TIMESTAMP_COUNTER_ENABLE  = 0;
   localparam int CTRL_FRAME_STAMP_ENABLE   = 1;
   localparam int CTRL_FMT_LO = 2;
   localparam int WCTL_IDLE   = 0;
   localparam int WCTL_STOP   = 1;
   localparam int WCTL_RUN    = 2;
   localparam int STAT_TX     = 0;
   localparam int QE_W        = 4;

   typedef enum logic [1:0] {
      FMT_SHORT = 2'h0,
      FMT_LONG  = 2'h1,
      FMT_FREE  = 2'h2
   } stamp_fmt_t;

   typedef enum logic [1:0] {
      W_IDLE  = 2'h0,
      W_ARMED = 2'h1,
      W_HIGH  = 2'h3,
      W_LOW   = 2'h2
   } wave_state_t;

endpackage

// File: src/free_run_counter.sv
// free running time counter, 120 MHz count rate emulated on the 25 MHz clock
// assumes enable is synchronous to clk
`timescale 1ns/100ps
`default_nettype none
module free_run_counter (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        enable,
   output logic      [31:0] count
);
   logic [4:0] frac;
   logic [5:0] fracSum;

   assign fracSum = {1'b0, frac} + {1'b0, ptp_time_pkg::FREE_FRAC};

   // whole counts plus one extra whenever the remainder overflows, so the
   // average rate is exact; 32 bits wrap after roughly 35 s
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count <= 32'h0;
         frac  <= 5'h0;
      end else if (enable) begin // R3
         if (fracSum >= {1'b0, ptp_time_pkg::FREE_DEN}) begin
            count <= count + ptp_time_pkg::FREE_WHOLE + 32'h1; // R1 R2
            frac  <= 5'(fracSum - {1'b0, ptp_time_pkg::FREE_DEN});
         end else begin
            count <= count + ptp_time_pkg::FREE_WHOLE; // R1 R2
            frac  <= fracSum[4:0];
         end
      end
   end
endmodule
`default_nettype wire

// File: src/wave_gen.sv
// waveform generator paced by syntonized time
// assumes timeNs advances by NS_STEP on each clock while tick is high
`timescale 1ns/100ps
`default_nettype none
module wave_gen (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        tick,
   input  wire logic [31:0] timeNs,
   input  wire logic [31:0] highPeriod,
   input  wire logic [31:0] lowPeriod,
   input  wire logic [3:0]  quantCorr,
   input  wire logic [31:0] startTime,
   input  wire logic        armPulse,
   input  wire logic        stopPulse,
   input  wire logic        idleLevel,
   output logic             waveOut,
   output logic             running
);
   ptp_time_pkg::wave_state_t state;
   logic [31:0] remain;
   logic        lastStep;
   logic        startHit;

   // start lands inside the time slice covered by this clock
   assign startHit = (32'(startTime - timeNs) < ptp_time_pkg::NS_STEP);
   assign lastStep = (remain <= ptp_time_pkg::NS_STEP);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state   <= ptp_time_pkg::W_IDLE;
         remain  <= 32'h0;
         waveOut <= 1'b0;
         running <= 1'b0;
      end else if (stopPulse) begin
         state   <= ptp_time_pkg::W_IDLE; // R17
         waveOut <= idleLevel; // R18
         running <= 1'b0;
      end else begin
         unique case (state)
            ptp_time_pkg::W_IDLE: begin
               waveOut <= idleLevel; // R15
               if (armPulse) begin
                  state <= ptp_time_pkg::W_ARMED;
               end
            end
            ptp_time_pkg::W_ARMED: begin
               waveOut <= idleLevel;
               if (tick && startHit) begin // R14
                  state   <= ptp_time_pkg::W_HIGH;
                  remain  <= highPeriod;
                  waveOut <= ~idleLevel; // R19
                  running <= 1'b1;
               end
            end
            ptp_time_pkg::W_HIGH: begin
               if (tick && lastStep) begin
                  state   <= ptp_time_pkg::W_LOW;
                  remain  <= lowPeriod + remain - ptp_time_pkg::NS_STEP; // R19
                  waveOut <= idleLevel;
               end else if (tick) begin
                  remain <= remain - ptp_time_pkg::NS_STEP;
               end
            end
            ptp_time_pkg::W_LOW: begin
               // correction stretches every cycle after the first by up to 15 ns
               if (tick && lastStep) begin
                  state   <= ptp_time_pkg::W_HIGH;
                  remain  <= highPeriod + 32'(quantCorr) + remain
                             - ptp_time_pkg::NS_STEP; // R13
                  waveOut <= ~idleLevel; // R19
               end else if (tick) begin
                  remain <= remain - ptp_time_pkg::NS_STEP;
               end
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// File: tb/ptp_time_counter_waveform_tb_top.sv
// bench for the time keeping block: apb register tests and port checks
// assumes an apb slave that answers within a few cycles of each setup
`timescale 1ns/100ps
`default_nettype none
module ptp_time_counter_waveform_tb_top;
   logic        clk, rst_n, psel, penable, pwrite, capIn, rxGo, txGo, txReq;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, q, a;
   logic [63:0] rxStamp;
   logic        pready, pslverr, rxStampValid, rxStampWide, waveOutput, slvErr;
   int          error_cnt = 0, compares = 0, cycles = 0, n, hi, lo;

   ptp_time_counter_waveform dut_u (.clk(clk), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .freeCountCaptureInput(capIn), .rxFrameStart(rxGo), .txFrameStart(txGo),
      .txCaptureRequest(txReq), .rxStamp(rxStamp), .rxStampValid(rxStampValid),
      .rxStampWide(rxStampWide), .waveOutput(waveOutput));

   // -------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish;
      if (error_cnt == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic tk(input int k);
      repeat (k) @(posedge clk);
   endtask

   // entered just after an edge; one idle edge after release avoids a double drive
   task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      tk(1);
      penable <= 1'b1;
      tk(1);
      // only the bench timeout ends a wait for the slave
      while (pready !== 1'b1) begin
         tk(1);
      end
      q = prdata;
      slvErr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      tk(1);
   endtask

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         error_cnt++;
         tally_and_finish();
      end
   end

   // -------------------------------------------------------------
   // tests
   // -------------------------------------------------------------
   initial begin
      rst_n = 1'b0;
      {psel, penable, pwrite, capIn, rxGo, txGo, txReq} = 7'h00;
      paddr = 8'h00;
      pwdata = 32'h0;
      tk(6);
      rst_n <= 1'b1;
      tk(1);
      chk(waveOutput, 0);
      apb(0, ptp_time_pkg::ADDR_ONE_SEC, 0);
      chk(q, ptp_time_pkg::ONE_SEC_RESET);
      apb(0, ptp_time_pkg::ADDR_FREE, 0);
      a = q;
      tk(10);
      apb(0, ptp_time_pkg::ADDR_FREE, 0);
      chk(q, a);
      apb(0, ptp_time_pkg::ADDR_NS, 0);
      chk(q, 0);
      apb(1, ptp_time_pkg::ADDR_CTRL, 1);
      // reads 50 clocks apart: 240 counts at 120 MHz, 2000 ns
      apb(0, ptp_time_pkg::ADDR_FREE, 0);
      a = q;
      tk(47);
      apb(0, ptp_time_pkg::ADDR_FREE, 0);
      chk(q - a, 240);
      apb(0, ptp_time_pkg::ADDR_NS, 0);
      a = q;
      tk(47);
      apb(0, ptp_time_pkg::ADDR_NS, 0);
      chk(q - a, 2000);
      apb(1, ptp_time_pkg::ADDR_ONE_SEC, 400);
      apb(0, ptp_time_pkg::ADDR_SEC, 0);
      a = q;
      tk(47);
      apb(0, ptp_time_pkg::ADDR_SEC, 0);
      chk(32'(q - a >= 4 && q - a <= 5), 1);
      for (n = 0; n < 6; n++) begin
         apb(0, ptp_time_pkg::ADDR_NS, 0);
         chk(32'(q <= 400 && q % 40 == 0), 1);
      end
      apb(1, ptp_time_pkg::ADDR_ONE_SEC, ptp_time_pkg::ONE_SEC_RESET);
      apb(1, ptp_time_pkg::ADDR_CTRL, 0);
      apb(0, ptp_time_pkg::ADDR_FREE, 0);
      a = q;
      capIn <= 1'b1;
      tk(2);
      capIn <= 1'b0;
      apb(0, ptp_time_pkg::ADDR_FREE_CAPT, 0);
      chk(q, a);
      for (n = 0; n < 4; n++) begin
         apb(1, ptp_time_pkg::ADDR_CTRL, (n == 3) ? 1 : 3 | (n << 2));
         rxGo <= 1'b1;
         tk(1);
         rxGo <= 1'b0;
         #1;
         chk(rxStampValid, n < 3);
         if (n < 3) chk(rxStampWide, n == 1);
         if (n == 1) chk(rxStamp[31:30], 0);
         else if (n < 3) chk(rxStamp[63:32], 0);
         if (n < 2) chk(rxStamp[29:0] % 40, 0);
         tk(1);
      end
      apb(1, ptp_time_pkg::ADDR_CTRL, 3);
      for (n = 0; n < 2; n++) begin
         txReq <= n[0];
         txGo <= 1'b1;
         tk(1);
         txGo <= 1'b0;
         tk(2);
         apb(0, ptp_time_pkg::ADDR_STATUS, 0);
         chk(q[0], n);
      end
      apb(1, ptp_time_pkg::ADDR_STATUS, 1);
      apb(0, ptp_time_pkg::ADDR_STATUS, 0);
      chk(q[0], 0);
      apb(1, ptp_time_pkg::ADDR_WAVE_HI, 160);
      apb(1, ptp_time_pkg::ADDR_WAVE_LO, 320);
      apb(1, ptp_time_pkg::ADDR_WAVE_QE, 32'h1F);
      apb(0, ptp_time_pkg::ADDR_WAVE_QE, 0);
      chk(q, 32'hF);
      apb(1, ptp_time_pkg::ADDR_WAVE_QE, 0);
      apb(0, ptp_time_pkg::ADDR_NS, 0);
      apb(1, ptp_time_pkg::ADDR_WAVE_GO, q + 1200);
      chk(waveOutput, 0);
      n = 0;
      while (waveOutput !== 1'b1 && n < 100) begin
         tk(1);
         n++;
      end
      hi = 0;
      lo = 0;
      while (waveOutput === 1'b1 && hi < 50) begin
         tk(1);
         hi++;
      end
      while (waveOutput === 1'b0 && lo < 50) begin
         tk(1);
         lo++;
      end
      chk(hi, 4);
      chk(lo, 8);
      apb(1, ptp_time_pkg::ADDR_WAVE_CTRL, 2);
      tk(3);
      chk(waveOutput, 0);
      tk(20);
      chk(waveOutput, 0);
      apb(0, ptp_time_pkg::ADDR_WAVE_CTRL, 0);
      chk(q, 0);
      apb(1, ptp_time_pkg::ADDR_WAVE_CTRL, 1);
      tk(3);
      chk(waveOutput, 1);
      apb(0, 8'h3C, 0);
      chk(slvErr, 1);
      chk(q, 0);
      tally_and_finish();
   end
endmodule
`default_nettype wire
